// ### rtl/cit_timer.sv
// Core interval timer: countdown, reload, expiry pin and two expiry interrupts.
// Assumes the core delivers register transfers as one-cycle write strobes with data,
// and that emulation state and the enable bit are on the core clock.
`timescale 1ns/10ps

// Function
// RL1: Enable bit set runs, clear stops timer.
// RL2: Decrement countdown by one each enabled cycle.
// RL3: Reload from interval cycle after zero.
// RL4: Expiries spaced interval plus one cycles.
// RL5: Reload interval register is 32 bits.
// RL6: At zero raise interrupt, pulse pin.
// RL7: Register reads have no side effects.
// RL8: Software countdown write beats reload, decrement.
// RL9: Countdown and interval not reset; software loads.
// RL10: Software loads registers while timer disabled.
// RL11: Start latency two, stop latency one.
// RL12: Expiry latches high and low interrupts.
// RL13: High-priority expiry serviced before low.
// RL14: Software unmasks only one expiry interrupt.
// RL15: Emulation halts timer, count held.
// RL16: Registers reached by core register transfers.
// RL17: Disabled timer holds count, no events.
module cit_timer
    import cit_pkg::*;
#(
    parameter int COUNT_W   = CIT_COUNT_W,
    parameter int PIN_CYCLES = CIT_PIN_CYCLES
) (
    input  wire logic               i_ref_clk,
    input  wire logic               i_reset,
    input  wire logic [CIT_MODE_W-1:0] i_mode_control_reg,
    input  wire logic               i_emulation,
    input  wire logic               i_countdown_wr,
    input  wire logic               i_reload_wr,
    input  wire logic [COUNT_W-1:0] i_wr_data,
    input  wire logic               i_irq_high_ack,
    input  wire logic               i_irq_low_ack,
    output logic      [COUNT_W-1:0] o_countdown_value,
    output logic      [COUNT_W-1:0] o_reload_interval,
    output logic                    o_expiry_irq_high,
    output logic                    o_expiry_irq_low,
    output logic                    o_expiry_output_pin
);
    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (COUNT_W != 32) begin : g_bad_width
        $error("COUNT_W must be 32.");
    end

    // ************************************************************
    // Enable latency
    // ************************************************************
    logic count_enable_bit;
    logic en_d1;
    logic en_d2;
    logic run;
    logic next_en_d1;
    logic next_en_d2;

    assign count_enable_bit = i_mode_control_reg[CIT_ENABLE_BIT];

    // Start needs two stages, stop takes effect after one stage.
    always_comb begin
        next_en_d1 = count_enable_bit;                  // see RL1
        next_en_d2 = en_d1 && count_enable_bit;         // see RL11
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            en_d1 <= 1'b0;
            en_d2 <= 1'b0;
        end else begin
            en_d1 <= next_en_d1;
            en_d2 <= next_en_d2;
        end
    end

    // Halted in emulation and while disabled.
    assign run = en_d2 && en_d1 && !i_emulation;        // see RL15, see RL17

    // ************************************************************
    // Counter and period
    // ************************************************************
    logic [COUNT_W-1:0] next_countdown;
    logic [COUNT_W-1:0] next_reload;
    logic               expire;

    assign expire = run && (o_countdown_value == '0);   // see RL6

    always_comb begin
        next_reload    = o_reload_interval;
        next_countdown = o_countdown_value;
        if (i_reload_wr) begin
            next_reload = i_wr_data;                    // see RL5
        end
        if (i_countdown_wr) begin
            next_countdown = i_wr_data;                 // see RL8
        end else if (expire) begin
            next_countdown = o_reload_interval;         // see RL3, see RL4
        end else if (run) begin
            next_countdown = o_countdown_value - 1'b1;  // see RL2
        end
    end

    // No reset on the count registers; reads are plain wires.
    always_ff @(posedge i_ref_clk) begin                // see RL9, see RL7
        o_countdown_value <= next_countdown;
        o_reload_interval <= next_reload;
    end

    // ************************************************************
    // Expiry interrupts
    // ************************************************************
    logic next_irq_high;
    logic next_irq_low;

    // Both requests latch together; a new expiry wins over an ack.
    // The core services the high request first when both are unmasked (see RL13).
    always_comb begin
        next_irq_high = expire || (o_expiry_irq_high && !i_irq_high_ack); // see RL12
        next_irq_low  = expire || (o_expiry_irq_low && !i_irq_low_ack);   // see RL12
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_expiry_irq_high <= 1'b0;
            o_expiry_irq_low  <= 1'b0;
        end else begin
            o_expiry_irq_high <= next_irq_high;
            o_expiry_irq_low  <= next_irq_low;
        end
    end

    // ************************************************************
    // Expiry pin
    // ************************************************************
    cit_pulse_stretch #(
        .LENGTH    (PIN_CYCLES)
    ) u_pin (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_trigger (expire),                            // see RL6
        .o_pulse   (o_expiry_output_pin)
    );
endmodule

// ### rtl/cit_pkg.sv
// Package of constants for the core interval timer.
// Assumes a single core clock domain; no bus, registers reached by core transfers.
package cit_pkg;
    localparam int          CIT_COUNT_W      = 32;
    localparam int          CIT_MODE_W       = 32;
    localparam int          CIT_ENABLE_BIT   = 5;
    localparam int          CIT_START_LAT    = 2;
    localparam int          CIT_STOP_LAT     = 1;
    localparam real         CIT_CLK_NS       = 25.0;
    localparam real         CIT_PIN_NS       = 100.0;
    localparam int          CIT_PIN_CYCLES   = int'(CIT_PIN_NS / CIT_CLK_NS);
    localparam logic [31:0] CIT_COUNT_RESET  = 32'h0000_0000;
endpackage

// ### rtl/cit_pulse_stretch.sv
// Stretches a one-cycle strobe into a pulse of a fixed number of cycles.
// Assumes the strobe is synchronous to the clock.
`timescale 1ns/10ps
module cit_pulse_stretch
    import cit_pkg::*;
#(
    parameter int LENGTH = CIT_PIN_CYCLES
) (
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    input  wire logic i_trigger,
    output logic      o_pulse
);
    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (LENGTH < 1 || LENGTH > 255) begin : g_bad_len
        $error("LENGTH out of range.");
    end

    logic [7:0] remain;
    logic [7:0] next_remain;
    logic       next_pulse;

    always_comb begin
        next_remain = remain;
        if (i_trigger) begin
            next_remain = 8'(LENGTH - 1);
        end else if (remain != 8'h00) begin
            next_remain = remain - 8'h01;
        end
        next_pulse = i_trigger || (remain != 8'h00);
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            remain  <= 8'h00;
            o_pulse <= 1'b0;
        end else begin
            remain  <= next_remain;
            o_pulse <= next_pulse;
        end
    end
endmodule

// ### test/cit_timer_checker.sv
// Port checker for the core interval timer.
// Assumes it is bound to every cit_timer instance.
`timescale 1ns/10ps
module cit_timer_checker
    import cit_pkg::*;
#(
    parameter int COUNT_W    = CIT_COUNT_W,
    parameter int PIN_CYCLES = CIT_PIN_CYCLES
) (
    input wire logic                  i_ref_clk,
    input wire logic                  i_reset,
    input wire logic [CIT_MODE_W-1:0] i_mode_control_reg,
    input wire logic                  i_emulation,
    input wire logic                  i_countdown_wr,
    input wire logic                  i_reload_wr,
    input wire logic [COUNT_W-1:0]    i_wr_data,
    input wire logic                  i_irq_high_ack,
    input wire logic                  i_irq_low_ack,
    input wire logic [COUNT_W-1:0]    o_countdown_value,
    input wire logic [COUNT_W-1:0]    o_reload_interval,
    input wire logic                  o_expiry_irq_high,
    input wire logic                  o_expiry_irq_low,
    input wire logic                  o_expiry_output_pin
);
    logic en_d1;
    logic en_d2;
    logic loaded;
    wire  run  = en_d1 && en_d2 && !i_emulation;
    wire  hit  = run && o_countdown_value == '0;
    wire  zero = hit && !i_countdown_wr;
    // Mirrors the two-edge start and one-edge stop of the enable bit.
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            en_d1 <= 1'b0;
            en_d2  <= 1'b0;
            loaded <= 1'b0;
        end else begin
            en_d1  <= i_mode_control_reg[CIT_ENABLE_BIT];
            en_d2  <= en_d1;
            loaded <= loaded || i_countdown_wr;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    sequence s_pin; o_expiry_output_pin[*4] ##1 !o_expiry_output_pin; endsequence
    property p_dec; run && !i_countdown_wr && !hit |=>
        o_countdown_value == $past(o_countdown_value) - 1; endproperty
    property p_reload; zero |=> o_countdown_value == $past(o_reload_interval); endproperty
    property p_irq; zero |=> o_expiry_irq_high && o_expiry_irq_low; endproperty
    property p_pin; $rose(o_expiry_output_pin) |-> s_pin; endproperty
    property p_hold; loaded && !run && !i_countdown_wr |=> $stable(o_countdown_value);
    endproperty
    property p_cause; $rose(o_expiry_irq_high) |-> $past(hit); endproperty
    property p_ack; o_expiry_irq_low && i_irq_low_ack && !hit |=> !o_expiry_irq_low; endproperty
    property p_wr; i_countdown_wr |=> o_countdown_value == $past(i_wr_data); endproperty
    a_dec: assert property (p_dec) else $error("count did not step down");
    a_reload: assert property (p_reload) else $error("no reload");
    a_irq: assert property (p_irq) else $error("requests not latched");
    a_pin: assert property (p_pin) else $error("pin pulse length");
    a_hold: assert property (p_hold) else $error("count moved");
    a_cause: assert property (p_cause) else $error("stray request");
    a_ack: assert property (p_ack) else $error("request not cleared");
    a_wr: assert property (p_wr) else $error("write lost");
endmodule

bind cit_timer cit_timer_checker #(.COUNT_W(COUNT_W), .PIN_CYCLES(PIN_CYCLES)) u_chk (.*);

// ### test/testbench.sv
// Self-checking bench for the core interval timer.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/10ps
module testbench;
    import cit_pkg::*;
    logic        clk = 0, rst = 1, emu = 0, cwr = 0, rwr = 0, ack = 0;
    logic [31:0] mode = '0, data = '0, cnt, rel;
    logic        irh, irl, pin;
    int          n_errors = 0, comparisons = 0;
    cit_timer DUT (.i_ref_clk(clk), .i_reset(rst), .i_mode_control_reg(mode),
        .i_emulation(emu), .i_countdown_wr(cwr), .i_reload_wr(rwr), .i_wr_data(data),
        .i_irq_high_ack(ack), .i_irq_low_ack(ack), .o_countdown_value(cnt),
        .o_reload_interval(rel), .o_expiry_irq_high(irh), .o_expiry_irq_low(irl),
        .o_expiry_output_pin(pin));
    initial forever #12.5 clk = ~clk;
    task chk(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t %h %h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic c, input logic [31:0] d);
        @(posedge clk);
        cwr <= c;
        rwr <= !c;
        data <= d;
        @(posedge clk);
        cwr <= 0;
        rwr <= 0;
        #1;
    endtask
    task set_en(input logic b);
        @(posedge clk);
        mode[CIT_ENABLE_BIT] <= b;
        #1;
    endtask
    task t_run;
        wr(0, 32'h5);
        wr(1, 32'h2);
        chk(rel, 32'h5);
        tick(3);
        chk(cnt, 32'h2);
        set_en(1);
        tick(2);
        chk(cnt, 32'h2);
        tick(1);
        chk(cnt, 32'h1);
        tick(2);
        chk({cnt[3:0], irh, irl, pin}, 7'h2f);
        @(posedge clk);
        ack <= 1;
        @(posedge clk);
        ack <= 0;
        tick(4);
        chk({cnt, irh}, {32'h5, 1'b1});
    endtask
    task t_stop;
        ack <= 1;
        tick(1);
        ack <= 0;
        tick(1);
        set_en(0);
        chk(cnt, 32'h2);
        tick(1);
        chk(cnt, 32'h1);
        emu <= 1;
        set_en(1);
        tick(5);
        chk({cnt, irh}, {32'h1, 1'b0});
        emu <= 0;
        wr(1, 32'h20);
        chk(cnt, 32'h20);
    endtask
    task end_of_test;
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        t_run;
        t_stop;
        tick(20);
        end_of_test;
    end
endmodule
